// [rtl/eid_pkg.sv]
// Overview of operation
// - OR accumulator into memory operand, write back to memory, update only zero flag.
// - Rotate memory left: bit i moves to i+1, bit 7 to bit 0, no flags.
// - Accumulator rotates put result in accumulator, memory unchanged, same flags.
// - Rotate left through carry: old carry into bit 0, bit 7 into carry.
// - Rotate right: bit i+1 moves to i, bit 0 to bit 7, no flags.
// - Rotate right through carry: old carry into bit 7, bit 0 into carry.
// - Borrow subtract: acc minus operand minus inverted carry, six flags updated.
// - Plain subtract: acc minus operand, no borrow in, same six flags.
// - Subtraction carry is 0 when result negative, 1 when zero or positive.
// - Memory forms of both subtractions write difference to memory, same flags.
// - Decrement memory, write back, skip when new value zero, no flags.
// - Increment memory, write back, skip when new value zero, no flags.
// - Accumulator dec/inc forms write only accumulator, skip when it is zero.
// - A taken skip inserts one dummy cycle, three cycles in total.
// - Set byte writes all ones to memory operand, no flags.
// - Set bit forces only selected bit to one, no flags.
// - Bit test skips when selected bit is not zero, no flags.
// - Byte test reads and rewrites operand, skips when non-zero, no flags.
// - Nibble swap exchanges halves; accumulator form leaves memory unchanged; no flags.
// - Byte skip-if-zero skips when operand equals zero.
// - Operand address reaches any data memory location directly, no banking.
package eid_pkg;

    // ****************************************
    // Register map (byte addresses)
    // ****************************************
    localparam logic [7:0] OFS_CMD   = 8'h00;
    localparam logic [7:0] OFS_ACC   = 8'h04;
    localparam logic [7:0] OFS_FLAGS = 8'h08;
    localparam logic [7:0] OFS_MADDR = 8'h0C;
    localparam logic [7:0] OFS_MDATA = 8'h10;
    localparam logic [7:0] OFS_STAT  = 8'h14;

    // ****************************************
    // Fields and reset values
    // ****************************************
    localparam int CMD_OP_LSB   = 0;
    localparam int CMD_BIT_LSB  = 5;
    localparam int CMD_ADDR_LSB = 8;
    localparam int FLAG_C  = 0;
    localparam int FLAG_AC = 1;
    localparam int FLAG_Z  = 2;
    localparam int FLAG_OV = 3;
    localparam int FLAG_SC = 4;
    localparam int FLAG_CZ = 5;
    localparam int STAT_BUSY   = 0;
    localparam int STAT_SKIP   = 1;
    localparam int STAT_BADOP  = 2;
    localparam int STAT_CYCLSB = 4;
    localparam logic [7:0] ACC_RST   = 8'h00;
    localparam logic [5:0] FLAGS_RST = 6'h00;
    localparam logic [7:0] ALL_ONES  = 8'hFF;
    localparam logic [1:0] CYC_PLAIN = 2'h2;
    localparam logic [1:0] CYC_SKIP  = 2'h3;

    typedef enum logic [4:0] {
        OP_OR_M = 5'h00, OP_RL_M = 5'h01, OP_RL_A = 5'h02, OP_RLC_M = 5'h03,
        OP_RLC_A = 5'h04, OP_RR_M = 5'h05, OP_RR_A = 5'h06, OP_RRC_M = 5'h07,
        OP_RRC_A = 5'h08, OP_SBC_A = 5'h09, OP_SBC_M = 5'h0A, OP_SUB_A = 5'h0B,
        OP_SUB_M = 5'h0C, OP_SDZ_M = 5'h0D, OP_SDZ_A = 5'h0E, OP_SIZ_M = 5'h0F,
        OP_SIZ_A = 5'h10, OP_SET_M = 5'h11, OP_SETB_M = 5'h12, OP_SNZB = 5'h13,
        OP_SNZ_M = 5'h14, OP_SWAP_M = 5'h15, OP_SWAP_A = 5'h16, OP_SZ_M = 5'h17
    } eid_op_type;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_READ  = 2'b01,
        ST_WRITE = 2'b11,
        ST_DUMMY = 2'b10
    } eid_state_type;

endpackage

// [rtl/eid_datapath.sv]
`timescale 1ns/1ps
module eid_datapath #(
    parameter int ADDR_W = 8
) (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             busy,
    output logic             dummyCycle
);

    localparam int DEPTH = 1 << ADDR_W;

    if (ADDR_W < 1 || ADDR_W > 8) begin : g_bad_width
        $error("ADDR_W must lie between 1 and 8");
    end

    // ****************************************
    // State
    // ****************************************
    eid_pkg::eid_state_type st;
    eid_pkg::eid_state_type next_st;
    eid_pkg::eid_op_type    opReg;
    logic [7:0]        dmem [DEPTH];
    logic [7:0]        acc;
    logic [5:0]        flags;
    logic [ADDR_W-1:0] addrReg;
    logic [ADDR_W-1:0] mAddr;
    logic [2:0]        bitReg;
    logic [7:0]        mOp;
    logic              lastSkip;
    logic              badOp;
    logic [1:0]        lastCyc;

    // ****************************************
    // APB decode
    // ****************************************
    wire        apbAccess = psel && penable && !pready;
    wire        apbFire   = psel && penable && pready;
    wire        selCmd    = paddr == eid_pkg::OFS_CMD;
    wire        selAcc    = paddr == eid_pkg::OFS_ACC;
    wire        selFlags  = paddr == eid_pkg::OFS_FLAGS;
    wire        selMaddr  = paddr == eid_pkg::OFS_MADDR;
    wire        selMdata  = paddr == eid_pkg::OFS_MDATA;
    wire        selStat   = paddr == eid_pkg::OFS_STAT;
    wire        mapped    = selCmd | selAcc | selFlags | selMaddr | selMdata | selStat;
    wire        idle      = st == eid_pkg::ST_IDLE;
    // Command, accumulator, flag and memory-data registers may only be written while idle, so the engine never races software
    wire        wrBlocked = pwrite && !idle && (selCmd | selAcc | selFlags | selMdata);
    wire        apbErr    = !mapped || wrBlocked;
    wire        wrOk      = apbFire && pwrite && !pslverr;
    wire [4:0]  cmdOp     = pwdata[eid_pkg::CMD_OP_LSB +: 5];
    wire        cmdValid  = cmdOp <= eid_pkg::OP_SZ_M;
    wire        cmdGo     = wrOk && selCmd && cmdValid;
    wire [7:0]  statVal   = {2'h0, lastCyc, 1'b0, badOp, lastSkip, !idle};
    wire [31:0] rdMux     = selCmd   ? {16'h0, 8'(addrReg), bitReg, 5'(opReg)} :
                            selAcc   ? {24'h0, acc} :
                            selFlags ? {26'h0, flags} :
                            selMaddr ? {24'h0, 8'(mAddr)} :
                            selMdata ? {24'h0, dmem[mAddr]} :
                            selStat  ? {24'h0, statVal} : 32'h0;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else begin
            pready  <= apbAccess;
            pslverr <= apbAccess && apbErr;
            prdata  <= (apbAccess && !pwrite) ? rdMux : 32'h0;
        end
    end

    // ****************************************
    // Operation datapath
    // ****************************************
    wire        isSbc    = opReg == eid_pkg::OP_SBC_A || opReg == eid_pkg::OP_SBC_M;
    wire        borrowIn = isSbc && !flags[eid_pkg::FLAG_C];
    wire [8:0]  diff9    = {1'b0, acc} - {1'b0, mOp} - {8'h0, borrowIn};
    wire [4:0]  diffLo   = {1'b0, acc[3:0]} - {1'b0, mOp[3:0]} - {4'h0, borrowIn};
    wire [7:0]  subV     = diff9[7:0];
    wire        subOv    = (acc[7] != mOp[7]) && (subV[7] != acc[7]);
    wire [7:0]  orV      = acc | mOp;
    wire [7:0]  rlV      = {mOp[6:0], mOp[7]};
    wire [7:0]  rlcV     = {mOp[6:0], flags[eid_pkg::FLAG_C]};
    wire [7:0]  rrV      = {mOp[0], mOp[7:1]};
    wire [7:0]  rrcV     = {flags[eid_pkg::FLAG_C], mOp[7:1]};
    wire [7:0]  decV     = mOp - 8'h01;
    wire [7:0]  incV     = mOp + 8'h01;
    wire [7:0]  bitMask  = 8'h01 << bitReg;
    wire [7:0]  swapV    = {mOp[3:0], mOp[7:4]};

    logic [7:0] res;
    logic       wrMem;
    logic       wrAcc;
    logic       skipNow;
    logic [5:0] next_flags;

    always_comb begin
        res        = mOp;
        wrMem      = 1'b0;
        wrAcc      = 1'b0;
        skipNow    = 1'b0;
        next_flags = flags;
        unique case (opReg)
            eid_pkg::OP_OR_M: begin
                res   = orV;
                wrMem = 1'b1;
                next_flags[eid_pkg::FLAG_Z] = orV == 8'h00;
            end
            eid_pkg::OP_RL_M: begin
                res   = rlV;
                wrMem = 1'b1;
            end
            eid_pkg::OP_RL_A: begin
                res   = rlV;
                wrAcc = 1'b1;
            end
            eid_pkg::OP_RLC_M, eid_pkg::OP_RLC_A: begin
                res   = rlcV;
                wrMem = opReg == eid_pkg::OP_RLC_M;
                wrAcc = opReg == eid_pkg::OP_RLC_A;
                next_flags[eid_pkg::FLAG_C] = mOp[7];
            end
            eid_pkg::OP_RR_M: begin
                res   = rrV;
                wrMem = 1'b1;
            end
            eid_pkg::OP_RR_A: begin
                res   = rrV;
                wrAcc = 1'b1;
            end
            eid_pkg::OP_RRC_M, eid_pkg::OP_RRC_A: begin
                res   = rrcV;
                wrMem = opReg == eid_pkg::OP_RRC_M;
                wrAcc = opReg == eid_pkg::OP_RRC_A;
                next_flags[eid_pkg::FLAG_C] = mOp[0];
            end
            eid_pkg::OP_SBC_A, eid_pkg::OP_SBC_M,
            eid_pkg::OP_SUB_A, eid_pkg::OP_SUB_M: begin
                res   = subV;
                wrAcc = opReg == eid_pkg::OP_SBC_A || opReg == eid_pkg::OP_SUB_A;
                wrMem = !wrAcc;
                next_flags[eid_pkg::FLAG_C]  = !diff9[8];
                next_flags[eid_pkg::FLAG_AC] = !diffLo[4];
                next_flags[eid_pkg::FLAG_Z]  = subV == 8'h00;
                next_flags[eid_pkg::FLAG_OV] = subOv;
                next_flags[eid_pkg::FLAG_SC] = subV[7] ^ subOv;
                // Chained zero holds only if every byte of a multi-byte borrow chain was zero
                next_flags[eid_pkg::FLAG_CZ] = (subV == 8'h00) &&
                                               (!isSbc || flags[eid_pkg::FLAG_CZ]);
            end
            eid_pkg::OP_SDZ_M: begin
                res     = decV;
                wrMem   = 1'b1;
                skipNow = decV == 8'h00;
            end
            eid_pkg::OP_SDZ_A: begin
                res     = decV;
                wrAcc   = 1'b1;
                skipNow = decV == 8'h00;
            end
            eid_pkg::OP_SIZ_M: begin
                res     = incV;
                wrMem   = 1'b1;
                skipNow = incV == 8'h00;
            end
            eid_pkg::OP_SIZ_A: begin
                res     = incV;
                wrAcc   = 1'b1;
                skipNow = incV == 8'h00;
            end
            eid_pkg::OP_SET_M: begin
                res   = eid_pkg::ALL_ONES;
                wrMem = 1'b1;
            end
            eid_pkg::OP_SETB_M: begin
                res   = mOp | bitMask;
                wrMem = 1'b1;
            end
            eid_pkg::OP_SNZB: begin
                skipNow = (mOp & bitMask) != 8'h00;
            end
            eid_pkg::OP_SNZ_M: begin
                wrMem   = 1'b1;
                skipNow = mOp != 8'h00;
            end
            eid_pkg::OP_SWAP_M: begin
                res   = swapV;
                wrMem = 1'b1;
            end
            eid_pkg::OP_SWAP_A: begin
                res   = swapV;
                wrAcc = 1'b1;
            end
            eid_pkg::OP_SZ_M: begin
                wrMem   = 1'b1;
                skipNow = mOp == 8'h00;
            end
            default: begin
                res = mOp;
            end
        endcase
    end

    // ****************************************
    // Sequencer
    // ****************************************
    always_comb begin
        next_st = st;
        unique case (st)
            eid_pkg::ST_IDLE:  next_st = cmdGo ? eid_pkg::ST_READ : eid_pkg::ST_IDLE;
            eid_pkg::ST_READ:  next_st = eid_pkg::ST_WRITE;
            eid_pkg::ST_WRITE: next_st = skipNow ? eid_pkg::ST_DUMMY
                                                 : eid_pkg::ST_IDLE;
            eid_pkg::ST_DUMMY: next_st = eid_pkg::ST_IDLE;
        endcase
    end

    wire inWrite = st == eid_pkg::ST_WRITE;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            st         <= eid_pkg::ST_IDLE;
            busy       <= 1'b0;
            dummyCycle <= 1'b0;
        end else begin
            st         <= next_st;
            busy       <= next_st != eid_pkg::ST_IDLE;
            dummyCycle <= next_st == eid_pkg::ST_DUMMY;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            opReg    <= eid_pkg::OP_OR_M;
            bitReg   <= 3'h0;
            addrReg  <= '0;
            mAddr    <= '0;
            lastSkip <= 1'b0;
            badOp    <= 1'b0;
            lastCyc  <= 2'h0;
        end else begin
            if (cmdGo) begin
                opReg   <= eid_pkg::eid_op_type'(cmdOp);
                bitReg  <= pwdata[eid_pkg::CMD_BIT_LSB +: 3];
                // Full address taken straight from the command, no bank select
                addrReg <= pwdata[eid_pkg::CMD_ADDR_LSB +: ADDR_W];
            end
            if (wrOk && selCmd) begin
                badOp <= !cmdValid;
            end
            if (wrOk && selMaddr) begin
                mAddr <= pwdata[ADDR_W-1:0];
            end
            if (inWrite) begin
                lastSkip <= skipNow;
                lastCyc  <= skipNow ? eid_pkg::CYC_SKIP : eid_pkg::CYC_PLAIN;
            end
        end
    end

    // ****************************************
    // Accumulator, flags, data memory
    // ****************************************
    always_ff @(posedge clk) begin
        if (!nrst) begin
            acc   <= eid_pkg::ACC_RST;
            flags <= eid_pkg::FLAGS_RST;
        end else if (inWrite) begin
            if (wrAcc) begin
                acc <= res;
            end
            flags <= next_flags;
        end else begin
            if (wrOk && selAcc) begin
                acc <= pwdata[7:0];
            end
            if (wrOk && selFlags) begin
                flags <= pwdata[5:0];
            end
        end
    end

    // Memory contents are data, not control, so they carry no reset
    always_ff @(posedge clk) begin
        if (st == eid_pkg::ST_READ) begin
            mOp <= dmem[addrReg];
        end
        if (inWrite && wrMem) begin
            dmem[addrReg] <= res;
        end else if (wrOk && selMdata) begin
            dmem[mAddr] <= pwdata[7:0];
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    wire [5:0] zMask = 6'h01 << eid_pkg::FLAG_Z;
    wire [5:0] cMask = 6'h01 << eid_pkg::FLAG_C;

    chk_or_mem_zero: assert property (
        inWrite && opReg == eid_pkg::OP_OR_M |=>
            dmem[$past(addrReg)] == ($past(acc) | $past(mOp)) &&
            flags[eid_pkg::FLAG_Z] == (($past(acc) | $past(mOp)) == 8'h00) &&
            (flags & ~zMask) == ($past(flags) & ~zMask))
        else $error("OR to memory result or flags wrong");

    chk_rotl_mem: assert property (
        inWrite && opReg == eid_pkg::OP_RL_M |=>
            dmem[$past(addrReg)] == {$past(mOp[6:0]), $past(mOp[7])} &&
            flags == $past(flags))
        else $error("Rotate left of memory wrong");

    chk_rot_acc_mem: assert property (
        inWrite && (opReg == eid_pkg::OP_RL_A || opReg == eid_pkg::OP_RRC_A) |=>
            dmem[$past(addrReg)] == $past(mOp) &&
            acc == (($past(opReg) == eid_pkg::OP_RL_A) ?
                    {$past(mOp[6:0]), $past(mOp[7])} :
                    {$past(flags[eid_pkg::FLAG_C]), $past(mOp[7:1])}))
        else $error("Accumulator rotate result or memory wrong");

    chk_rotl_carry: assert property (
        inWrite && opReg == eid_pkg::OP_RLC_A |=>
            acc == {$past(mOp[6:0]), $past(flags[eid_pkg::FLAG_C])} &&
            flags[eid_pkg::FLAG_C] == $past(mOp[7]) &&
            (flags & ~cMask) == ($past(flags) & ~cMask))
        else $error("Rotate left through carry wrong");

    chk_rotr_acc: assert property (
        inWrite && opReg == eid_pkg::OP_RR_A |=>
            acc == {$past(mOp[0]), $past(mOp[7:1])} && flags == $past(flags))
        else $error("Rotate right wrong");

    chk_rotr_carry: assert property (
        inWrite && opReg == eid_pkg::OP_RRC_M |=>
            dmem[$past(addrReg)] == {$past(flags[eid_pkg::FLAG_C]), $past(mOp[7:1])} &&
            flags[eid_pkg::FLAG_C] == $past(mOp[0]))
        else $error("Rotate right through carry wrong");

    chk_sbc_value: assert property (
        inWrite && opReg == eid_pkg::OP_SBC_A |=>
            acc == 8'($past(acc) - $past(mOp) - {7'h0, !$past(flags[eid_pkg::FLAG_C])}))
        else $error("Borrow subtract value wrong");

    chk_sub_carry: assert property (
        inWrite && opReg == eid_pkg::OP_SUB_M |=>
            flags[eid_pkg::FLAG_C] == ($past(acc) >= $past(mOp)) &&
            dmem[$past(addrReg)] == 8'($past(acc) - $past(mOp)))
        else $error("Subtract carry or memory result wrong");

    chk_skip_dummy: assert property (
        inWrite && skipNow |=> st == eid_pkg::ST_DUMMY && dummyCycle
            ##1 st == eid_pkg::ST_IDLE && !dummyCycle)
        else $error("Taken skip did not insert one dummy cycle");

    chk_noskip_two: assert property (
        inWrite && !skipNow |=> st == eid_pkg::ST_IDLE && !busy)
        else $error("Untaken skip did not end after two cycles");

    chk_set_byte: assert property (
        inWrite && opReg == eid_pkg::OP_SET_M |=>
            dmem[$past(addrReg)] == eid_pkg::ALL_ONES && flags == $past(flags))
        else $error("Set byte wrong");

    chk_swap_acc: assert property (
        inWrite && opReg == eid_pkg::OP_SWAP_A |=>
            acc == {$past(mOp[3:0]), $past(mOp[7:4])} &&
            dmem[$past(addrReg)] == $past(mOp))
        else $error("Nibble swap to accumulator wrong");

endmodule

// [verification/eid_seq_model.sv]
`timescale 1ns/1ps
// ****************************************
// Sequencer stand-in driving the APB side
// ****************************************
module eid_seq_model (
    input  wire logic        clk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end

    // Request held until pready is sampled; an idle edge always separates calls
    task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                        output logic [31:0] rdata, output logic err);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wdata;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Released lines carry junk so stale values are never mistaken for data
        paddr <= ~addr;
        pwdata <= ~wdata;
    endtask
endmodule

// [verification/eid_datapath_tb.sv]
`timescale 1ns/1ps
module eid_datapath_tb;
    localparam int CYCLE_LIMIT = 20000;
    logic        clk;
    logic        nrst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        busy;
    logic        dummyCycle;
    logic [31:0] rd;
    logic        err;
    int          numErrors = 0;
    int          nTests = 0;
    int          cycles = 0;
    int          busyCnt = 0;
    int          dummyCnt = 0;
    int          caseNo = 0;

    eid_seq_model eid_seq_model_i (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    eid_datapath #(.ADDR_W(8)) eid_datapath_i (.clk(clk), .nrst(nrst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .busy(busy), .dummyCycle(dummyCycle));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // ****************************************
    // Cycle counters and hang guard
    // ****************************************
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (busy === 1'b1) busyCnt <= busyCnt + 1;
        if (dummyCycle === 1'b1) dummyCnt <= dummyCnt + 1;
        if (cycles == CYCLE_LIMIT) begin
            numErrors++;
            completeRun();
        end
    end

    task automatic completeRun();
        $display("Comparisons %0d, mismatches %0d", nTests, numErrors);
        if (numErrors == 0 && nTests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        nTests++;
        if (seen !== exp) begin
            numErrors++;
            $display("FAIL %0t %s: got %0h expected %0h", $time, what, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        eid_seq_model_i.xfer(1'b1, a, d, rd, err);
    endtask

    task automatic rdChk(input logic [7:0] a, input logic [31:0] exp, input string what);
        eid_seq_model_i.xfer(1'b0, a, 32'h0, rd, err);
        check(rd, exp, what);
    endtask

    // Loads operands, runs one instruction, then checks results, flags and timing
    task automatic runOp(input eid_pkg::eid_op_type op, input logic [2:0] bn,
                         input logic [7:0] acc, input logic [7:0] mem, input logic [5:0] fl,
                         input logic [7:0] eAcc, input logic [7:0] eMem,
                         input logic [5:0] eFl, input logic sk);
        logic [7:0] addr;
        int         b0;
        int         d0;
        int         n;
        addr = 8'(caseNo * 37);
        caseNo++;
        wr(eid_pkg::OFS_MADDR, {24'h0, addr});
        wr(eid_pkg::OFS_MDATA, {24'h0, mem});
        wr(eid_pkg::OFS_ACC, {24'h0, acc});
        wr(eid_pkg::OFS_FLAGS, {26'h0, fl});
        b0 = busyCnt;
        d0 = dummyCnt;
        wr(eid_pkg::OFS_CMD, {16'h0, addr, bn, op});
        n = 0;
        do begin
            eid_seq_model_i.xfer(1'b0, eid_pkg::OFS_STAT, 32'h0, rd, err);
            n++;
        end while (rd[eid_pkg::STAT_BUSY] !== 1'b0 && n < 10);
        check(rd, {26'h0, sk ? eid_pkg::CYC_SKIP : eid_pkg::CYC_PLAIN, 2'b00, sk, 1'b0}, "stat");
        check(32'(busyCnt - b0), sk ? 32'h3 : 32'h2, "busy cycles");
        check(32'(dummyCnt - d0), {31'h0, sk}, "dummy cycles");
        rdChk(eid_pkg::OFS_ACC, {24'h0, eAcc}, "acc");
        rdChk(eid_pkg::OFS_FLAGS, {26'h0, eFl}, "flags");
        rdChk(eid_pkg::OFS_MDATA, {24'h0, eMem}, "mem");
        $display("Test op %0h done", op);
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        nrst = 1'b0;
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        rdChk(eid_pkg::OFS_ACC, {24'h0, eid_pkg::ACC_RST}, "acc reset");
        rdChk(eid_pkg::OFS_FLAGS, {26'h0, eid_pkg::FLAGS_RST}, "flags reset");
        rdChk(eid_pkg::OFS_MADDR, 32'h0, "maddr reset");
        eid_seq_model_i.xfer(1'b0, 8'h18, 32'h0, rd, err);
        check({31'h0, err}, 32'h1, "unmapped error");
        check(rd, 32'h0, "unmapped data");
        $display("Test reset and map done");
        runOp(eid_pkg::OP_OR_M, 3'h0, 8'h0F, 8'hF0, 6'h3F, 8'h0F, 8'hFF, 6'h3B, 1'b0);
        runOp(eid_pkg::OP_OR_M, 3'h0, 8'h00, 8'h00, 6'h00, 8'h00, 8'h00, 6'h04, 1'b0);
        runOp(eid_pkg::OP_RL_M, 3'h0, 8'h5A, 8'h81, 6'h15, 8'h5A, 8'h03, 6'h15, 1'b0);
        runOp(eid_pkg::OP_RL_A, 3'h0, 8'h00, 8'h81, 6'h2A, 8'h03, 8'h81, 6'h2A, 1'b0);
        runOp(eid_pkg::OP_RLC_M, 3'h0, 8'h11, 8'h80, 6'h3E, 8'h11, 8'h00, 6'h3F, 1'b0);
        runOp(eid_pkg::OP_RLC_A, 3'h0, 8'h00, 8'h01, 6'h01, 8'h03, 8'h01, 6'h00, 1'b0);
        runOp(eid_pkg::OP_RR_M, 3'h0, 8'h00, 8'h01, 6'h3F, 8'h00, 8'h80, 6'h3F, 1'b0);
        runOp(eid_pkg::OP_RR_A, 3'h0, 8'hFF, 8'h02, 6'h00, 8'h01, 8'h02, 6'h00, 1'b0);
        runOp(eid_pkg::OP_RRC_M, 3'h0, 8'h00, 8'h01, 6'h00, 8'h00, 8'h00, 6'h01, 1'b0);
        runOp(eid_pkg::OP_RRC_A, 3'h0, 8'h00, 8'h02, 6'h3F, 8'h81, 8'h02, 6'h3E, 1'b0);
        runOp(eid_pkg::OP_SUB_A, 3'h0, 8'h05, 8'h07, 6'h00, 8'hFE, 8'h07, 6'h10, 1'b0);
        runOp(eid_pkg::OP_SUB_A, 3'h0, 8'h80, 8'h01, 6'h00, 8'h7F, 8'h01, 6'h19, 1'b0);
        runOp(eid_pkg::OP_SUB_M, 3'h0, 8'h33, 8'h33, 6'h18, 8'h33, 8'h00, 6'h27, 1'b0);
        runOp(eid_pkg::OP_SBC_A, 3'h0, 8'h10, 8'h0F, 6'h20, 8'h00, 8'h0F, 6'h25, 1'b0);
        runOp(eid_pkg::OP_SBC_M, 3'h0, 8'h00, 8'h00, 6'h3E, 8'h00, 8'hFF, 6'h10, 1'b0);
        runOp(eid_pkg::OP_SDZ_M, 3'h0, 8'h00, 8'h01, 6'h3F, 8'h00, 8'h00, 6'h3F, 1'b1);
        runOp(eid_pkg::OP_SDZ_M, 3'h0, 8'h00, 8'h00, 6'h00, 8'h00, 8'hFF, 6'h00, 1'b0);
        runOp(eid_pkg::OP_SDZ_A, 3'h0, 8'h55, 8'h01, 6'h00, 8'h00, 8'h01, 6'h00, 1'b1);
        runOp(eid_pkg::OP_SIZ_M, 3'h0, 8'h00, 8'hFF, 6'h2A, 8'h00, 8'h00, 6'h2A, 1'b1);
        runOp(eid_pkg::OP_SIZ_A, 3'h0, 8'h00, 8'h10, 6'h00, 8'h11, 8'h10, 6'h00, 1'b0);
        runOp(eid_pkg::OP_SET_M, 3'h0, 8'h00, 8'h00, 6'h2A, 8'h00, 8'hFF, 6'h2A, 1'b0);
        runOp(eid_pkg::OP_SETB_M, 3'h7, 8'h00, 8'h01, 6'h15, 8'h00, 8'h81, 6'h15, 1'b0);
        runOp(eid_pkg::OP_SNZB, 3'h3, 8'h00, 8'h08, 6'h00, 8'h00, 8'h08, 6'h00, 1'b1);
        runOp(eid_pkg::OP_SNZB, 3'h2, 8'h00, 8'hFB, 6'h00, 8'h00, 8'hFB, 6'h00, 1'b0);
        runOp(eid_pkg::OP_SNZ_M, 3'h0, 8'h00, 8'h40, 6'h3F, 8'h00, 8'h40, 6'h3F, 1'b1);
        runOp(eid_pkg::OP_SNZ_M, 3'h0, 8'h00, 8'h00, 6'h00, 8'h00, 8'h00, 6'h00, 1'b0);
        runOp(eid_pkg::OP_SWAP_M, 3'h0, 8'h00, 8'h12, 6'h00, 8'h00, 8'h21, 6'h00, 1'b0);
        runOp(eid_pkg::OP_SWAP_A, 3'h0, 8'h00, 8'hA5, 6'h00, 8'h5A, 8'hA5, 6'h00, 1'b0);
        runOp(eid_pkg::OP_SZ_M, 3'h0, 8'h00, 8'h00, 6'h00, 8'h00, 8'h00, 6'h00, 1'b1);
        runOp(eid_pkg::OP_SZ_M, 3'h0, 8'h00, 8'h01, 6'h00, 8'h00, 8'h01, 6'h00, 1'b0);
        // Location 0 holds FFH, so this skip is taken and the dummy cycle catches the write
        wr(eid_pkg::OFS_ACC, 32'h77);
        wr(eid_pkg::OFS_CMD, {16'h0, 8'h00, 3'h0, eid_pkg::OP_SNZ_M});
        eid_seq_model_i.xfer(1'b1, eid_pkg::OFS_ACC, 32'h11, rd, err);
        check({31'h0, err}, 32'h1, "write while busy");
        rdChk(eid_pkg::OFS_ACC, 32'h77, "acc kept");
        wr(eid_pkg::OFS_CMD, 32'h18);
        eid_seq_model_i.xfer(1'b0, eid_pkg::OFS_STAT, 32'h0, rd, err);
        check({30'h0, rd[eid_pkg::STAT_BADOP], rd[eid_pkg::STAT_BUSY]}, 32'h2, "bad opcode");
        rdChk(eid_pkg::OFS_ACC, 32'h77, "acc after bad opcode");
        $display("Test refusals done");
        completeRun();
    end
endmodule
